// ---- logic/cfgdec_defs.svh ----
// Constants for the configuration word decoder: map, fields, timing
`ifndef CFGDEC_DEFS_SVH
`define CFGDEC_DEFS_SVH

// ==========================================================
// Bus and address map (word indices, byte address = 4 x index)
`define CFGDEC_AW           16
`define CFGDEC_IDX_W        14
`define CFGDEC_IDX_STATUS   14'h0000
`define CFGDEC_IDX_CTRL     14'h0001
`define CFGDEC_IDX_SPACE_LO 14'h2000
`define CFGDEC_IDX_SPACE_HI 14'h3FFF
`define CFGDEC_IDX_CFG      14'h2007
`define CFGDEC_NVM_WORDS    8
`define CFGDEC_NVM_IW       3
`define CFGDEC_RESP_OKAY    2'h0
`define CFGDEC_RESP_SLVERR  2'h2

// ==========================================================
// Configuration word fields
`define CFGDEC_WORD_W       14
`define CFGDEC_WORD_ERASED  14'h3FFF
`define CFGDEC_PP_HI        13
`define CFGDEC_PP_LO        4
`define CFGDEC_RCP_HI_HI    13
`define CFGDEC_RCP_HI_LO    8
`define CFGDEC_DMP_BIT      7
`define CFGDEC_RCP_LO_HI    6
`define CFGDEC_RCP_LO_LO    4
`define CFGDEC_PUDE_BIT     3
`define CFGDEC_WDEN_BIT     2
`define CFGDEC_OSC_HI_BIT   1
`define CFGDEC_OSC_LO_BIT   0
`define CFGDEC_OSC_RC       2'h3

// ==========================================================
// Status and control register fields
`define CFGDEC_ST_OSC_LO    0
`define CFGDEC_ST_OSC_HI    1
`define CFGDEC_ST_WDTEN     2
`define CFGDEC_ST_PWRTEN    3
`define CFGDEC_ST_PPROT     4
`define CFGDEC_ST_DPROT     5
`define CFGDEC_ST_PROG      6
`define CFGDEC_ST_SLEEP     7
`define CFGDEC_ST_WDTFLAG   8
`define CFGDEC_ST_RUN       9
`define CFGDEC_CT_SLEEP     0
`define CFGDEC_CT_WDTCLR    1
`define CFGDEC_CT_FLAGCLR   2
`define CFGDEC_CT_ERASE     3

// ==========================================================
// Timing
`define CFGDEC_CLK_KHZ      25000
`define CFGDEC_PUD_MS       72
`define CFGDEC_OSU_CYCLES   1024
`define CFGDEC_TICK_DIV     25
`define CFGDEC_TICK_W       5
`define CFGDEC_WDT_TICKS    18000
`define CFGDEC_WDT_W        16
`define CFGDEC_DLY_W        21

`endif

// ---- logic/cfgdec_pkg.sv ----
// Types for the configuration word decoder
`include "cfgdec_defs.svh"

package cfgdec_pkg;

	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		S_SYNC_A, S_SYNC_B, S_CAPTURE, S_PUD, S_OSU, S_RUN, S_MCLR, S_SLEEP
	} cfgdec_state_t;

	// ==========================================================
	// AXI4-Lite carriers
	typedef struct packed {
		logic                   awvalid;
		logic [`CFGDEC_AW-1:0]  awaddr;
		logic                   wvalid;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   bready;
		logic                   arvalid;
		logic [`CFGDEC_AW-1:0]  araddr;
		logic                   rready;
	} cfgdec_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} cfgdec_axi_rsp_t;

	// ==========================================================
	// Decoded configuration
	typedef struct packed {
		logic prog_protect;
		logic data_memory_protect_bit;
		logic powerup_delay_enable_n;
		logic watchdog_enable_cfg;
		logic osc_select_hi;
		logic osc_select_lo;
	} cfgdec_cfg_t;

	// ==========================================================
	// Module states
	typedef struct packed {
		logic [`CFGDEC_NVM_WORDS-1:0][`CFGDEC_WORD_W-1:0] word;
	} cfgdec_nvm_t;

	typedef struct packed {
		logic [`CFGDEC_DLY_W-1:0] cnt;
		logic                     busy;
		logic                     done;
	} cfgdec_dly_t;

	typedef struct packed {
		cfgdec_state_t            st;
		cfgdec_cfg_t              cfg;
		cfgdec_axi_rsp_t          rsp;
		logic                     aw_got;
		logic [`CFGDEC_AW-1:0]    awaddr;
		logic                     w_got;
		logic [31:0]              wdata;
		logic [3:0]               wstrb;
		logic [1:0]               mclr_s;
		logic [1:0]               osc_s;
		logic [1:0]               prog_s;
		logic [1:0]               rom_s;
		logic [`CFGDEC_TICK_W-1:0] tick_cnt;
		logic [`CFGDEC_WDT_W-1:0] wdt_cnt;
		logic                     wdt_flag;
		logic                     wdt_pulse;
		logic                     osu_armed;
		logic                     dev_reset_n;
		logic                     sleeping;
	} cfgdec_st_t;

endpackage

// ---- logic/cfgdec_nvm.sv ----
// Nonvolatile configuration space words, programmed and erased by the tool
`include "cfgdec_defs.svh"

module cfgdec_nvm (
	// Clock
	input  wire logic                        i_clk,
	// Programming port
	input  wire logic                        i_we,
	input  wire logic                        i_erase,
	input  wire logic [`CFGDEC_NVM_IW-1:0]   i_idx,
	input  wire logic [`CFGDEC_WORD_W-1:0]   i_wdata,
	input  wire logic [`CFGDEC_WORD_W-1:0]   i_wmask,
	// Stored words
	output cfgdec_pkg::cfgdec_nvm_t          o_mem
);

	// ==========================================================
	// Storage
	// No reset: contents survive every reset, as nonvolatile cells do
	cfgdec_pkg::cfgdec_nvm_t q;
	cfgdec_pkg::cfgdec_nvm_t d;

	always_comb begin
		d = q;
		if (i_erase) begin
			for (int i = 0; i < `CFGDEC_NVM_WORDS; i++) begin
				d.word[i] = `CFGDEC_WORD_ERASED;
			end
		end else if (i_we) begin
			// Programming only clears bits; erase is the only way back to 1
			d.word[i_idx] = q.word[i_idx] & ~(i_wmask & ~i_wdata);
		end
	end

	always_ff @(posedge i_clk) begin
		q <= d;
	end

	assign o_mem = q;

endmodule

// ---- logic/cfgdec_delay.sv ----
// Start-triggered cycle delay with a one-cycle done pulse
`include "cfgdec_defs.svh"

module cfgdec_delay #(
	parameter int unsigned CYCLES = 1
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Control
	input  wire logic i_start,
	output logic      o_done
);

	// ==========================================================
	// Counter
	cfgdec_pkg::cfgdec_dly_t q;
	cfgdec_pkg::cfgdec_dly_t d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		if (i_start) begin
			d.busy = 1'b1;
			d.cnt  = '0;
		end else if (q.busy) begin
			if (q.cnt == `CFGDEC_DLY_W'(CYCLES - 1)) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end else begin
				d.cnt = q.cnt + `CFGDEC_DLY_W'(1);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_done = q.done;

endmodule

// ---- logic/cfgdec_top.sv ----
// Configuration word decoder with reset timers, watchdog and AXI4-Lite access
//
// How it works
// - Config word lives at index 2007h and drives all device options.
// - Programmed bits read 0, unprogrammed bits read 1.
// - Indices 2000h-3FFFh reachable only in programming mode.
// - Flash variant: any zero in bits 13:4 protects all memory.
// - ROM variant: bit 7 protects data; bits 13:8 and 6:4 protect program.
// - Bit 3 low enables the power-up delay timer.
// - Bit 2 high enables the watchdog.
// - Bits 1:0 pick RC, high-speed, standard or low-power crystal mode.
// - Power-up delay holds reset 72 ms, only after power-on.
// - Start-up timer holds reset 1024 cycles after the crystal reports stable.
// - Watchdog runs on its own tick; only the config bit disables it.
// - Sleep ends on external reset, watchdog time-out or interrupt.
`include "cfgdec_defs.svh"

module cfgdec_top #(
	parameter int unsigned PUD_CYCLES  = `CFGDEC_PUD_MS * `CFGDEC_CLK_KHZ,
	parameter int unsigned WDT_TICKS   = `CFGDEC_WDT_TICKS
) (
	// Clock and power-on reset
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_n,
	// Register bus
	input  wire cfgdec_pkg::cfgdec_axi_req_t i_axi,
	output cfgdec_pkg::cfgdec_axi_rsp_t    o_axi,
	// Pins
	input  wire logic                      i_prog_mode,
	input  wire logic                      i_rom_variant,
	input  wire logic                      i_mclr_n,
	input  wire logic                      i_osc_stable,
	// Core interrupt request, same clock
	input  wire logic                      i_irq,
	// Decoded configuration and reset control
	output cfgdec_pkg::cfgdec_cfg_t        o_cfg,
	output logic                           o_dev_reset_n,
	output logic                           o_sleeping,
	output logic                           o_wdt_timeout
);

	// ==========================================================
	// Decoding helpers
	function automatic logic in_cfg_space(input logic [`CFGDEC_IDX_W-1:0] idx);
		in_cfg_space = (idx >= `CFGDEC_IDX_SPACE_LO) && (idx <= `CFGDEC_IDX_SPACE_HI);
	endfunction

	function automatic logic in_nvm(input logic [`CFGDEC_IDX_W-1:0] idx);
		in_nvm = (idx >= `CFGDEC_IDX_SPACE_LO)
			&& (idx < `CFGDEC_IDX_SPACE_LO + `CFGDEC_IDX_W'(`CFGDEC_NVM_WORDS));
	endfunction

	function automatic cfgdec_pkg::cfgdec_cfg_t decode(
		input logic [`CFGDEC_WORD_W-1:0] w,
		input logic                      rom
	);
		cfgdec_pkg::cfgdec_cfg_t c;
		c = '0;
		if (rom) begin
			c.prog_protect = ~&{w[`CFGDEC_RCP_HI_HI:`CFGDEC_RCP_HI_LO],
				w[`CFGDEC_RCP_LO_HI:`CFGDEC_RCP_LO_LO]};
			c.data_memory_protect_bit = ~w[`CFGDEC_DMP_BIT];
		end else begin
			c.prog_protect = ~&w[`CFGDEC_PP_HI:`CFGDEC_PP_LO];
			c.data_memory_protect_bit = c.prog_protect;
		end
		c.powerup_delay_enable_n = w[`CFGDEC_PUDE_BIT];
		c.watchdog_enable_cfg    = w[`CFGDEC_WDEN_BIT];
		c.osc_select_hi          = w[`CFGDEC_OSC_HI_BIT];
		c.osc_select_lo          = w[`CFGDEC_OSC_LO_BIT];
		decode = c;
	endfunction

	// ==========================================================
	// State and submodule wiring
	cfgdec_pkg::cfgdec_st_t  q;
	cfgdec_pkg::cfgdec_st_t  d;
	cfgdec_pkg::cfgdec_nvm_t nvm;

	logic                       nvm_we;
	logic                       nvm_erase;
	logic [`CFGDEC_WORD_W-1:0]  nvm_mask;
	logic                       pud_start;
	logic                       pud_done;
	logic                       osu_start;
	logic                       osu_done;
	logic                       tick;
	logic                       wdt_to;
	logic                       sleep_req;
	logic                       wdt_clr;
	logic                       flag_clr;
	logic                       aw_hs;
	logic                       w_hs;
	logic                       prog;
	logic [`CFGDEC_IDX_W-1:0]   widx;
	logic [`CFGDEC_IDX_W-1:0]   ridx;
	logic [31:0]                rword;
	logic [1:0]                 rresp;

	cfgdec_nvm u_nvm (
		.i_clk   (i_clk),
		.i_we    (nvm_we),
		.i_erase (nvm_erase),
		.i_idx   (widx[`CFGDEC_NVM_IW-1:0]),
		.i_wdata (q.wdata[`CFGDEC_WORD_W-1:0]),
		.i_wmask (nvm_mask),
		.o_mem   (nvm)
	);

	cfgdec_delay #(.CYCLES(PUD_CYCLES)) u_pud (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_start (pud_start),
		.o_done  (pud_done)
	);

	cfgdec_delay #(.CYCLES(`CFGDEC_OSU_CYCLES)) u_osu (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_start (osu_start),
		.o_done  (osu_done)
	);

	// ==========================================================
	// Next state
	always_comb begin
		d          = q;
		nvm_we     = 1'b0;
		nvm_erase  = 1'b0;
		pud_start  = 1'b0;
		osu_start  = 1'b0;
		sleep_req  = 1'b0;
		wdt_clr    = 1'b0;
		flag_clr   = 1'b0;
		rword      = '0;
		rresp      = `CFGDEC_RESP_OKAY;
		widx       = q.awaddr[`CFGDEC_AW-1:2];
		ridx       = i_axi.araddr[`CFGDEC_AW-1:2];
		prog       = q.prog_s[1];
		nvm_mask   = {{(`CFGDEC_WORD_W-8){q.wstrb[1]}}, {8{q.wstrb[0]}}};

		// Pin synchronisers
		d.mclr_s = {q.mclr_s[0], i_mclr_n};
		d.osc_s  = {q.osc_s[0], i_osc_stable};
		d.prog_s = {q.prog_s[0], i_prog_mode};
		d.rom_s  = {q.rom_s[0], i_rom_variant};

		// ======================================================
		// Write channel: address and data taken in either order
		aw_hs = i_axi.awvalid & q.rsp.awready;
		w_hs  = i_axi.wvalid & q.rsp.wready;
		if (aw_hs) begin
			d.aw_got = 1'b1;
			d.awaddr = i_axi.awaddr;
		end
		if (w_hs) begin
			d.w_got = 1'b1;
			d.wdata = i_axi.wdata;
			d.wstrb = i_axi.wstrb;
		end
		if (q.rsp.bvalid && i_axi.bready) begin
			d.rsp.bvalid = 1'b0;
		end
		if (q.aw_got && q.w_got && !q.rsp.bvalid) begin
			d.aw_got     = 1'b0;
			d.w_got      = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp  = `CFGDEC_RESP_OKAY;
			if (in_cfg_space(widx)) begin
				if (prog && in_nvm(widx)) begin
					nvm_we = 1'b1;
				end else if (!prog) begin
					d.rsp.bresp = `CFGDEC_RESP_SLVERR;
				end
			end else if (widx == `CFGDEC_IDX_CTRL) begin
				if (q.wstrb[0]) begin
					sleep_req = q.wdata[`CFGDEC_CT_SLEEP];
					wdt_clr   = q.wdata[`CFGDEC_CT_WDTCLR];
					flag_clr  = q.wdata[`CFGDEC_CT_FLAGCLR];
					nvm_erase = q.wdata[`CFGDEC_CT_ERASE] & prog;
				end
			end else if (widx != `CFGDEC_IDX_STATUS) begin
				d.rsp.bresp = `CFGDEC_RESP_SLVERR;
			end
		end
		d.rsp.awready = !d.aw_got && !d.rsp.bvalid;
		d.rsp.wready  = !d.w_got && !d.rsp.bvalid;

		// ======================================================
		// Read channel
		if (in_cfg_space(ridx)) begin
			if (!prog) begin
				rresp = `CFGDEC_RESP_SLVERR;
			end else if (in_nvm(ridx)) begin
				rword = 32'(nvm.word[ridx[`CFGDEC_NVM_IW-1:0]]);
			end else begin
				rword = 32'(`CFGDEC_WORD_ERASED);
			end
		end else if (ridx == `CFGDEC_IDX_STATUS) begin
			rword[`CFGDEC_ST_OSC_LO]  = q.cfg.osc_select_lo;
			rword[`CFGDEC_ST_OSC_HI]  = q.cfg.osc_select_hi;
			rword[`CFGDEC_ST_WDTEN]   = q.cfg.watchdog_enable_cfg;
			rword[`CFGDEC_ST_PWRTEN]  = ~q.cfg.powerup_delay_enable_n;
			rword[`CFGDEC_ST_PPROT]   = q.cfg.prog_protect;
			rword[`CFGDEC_ST_DPROT]   = q.cfg.data_memory_protect_bit;
			rword[`CFGDEC_ST_PROG]    = prog;
			rword[`CFGDEC_ST_SLEEP]   = q.sleeping;
			rword[`CFGDEC_ST_WDTFLAG] = q.wdt_flag;
			rword[`CFGDEC_ST_RUN]     = q.dev_reset_n;
		end else if (ridx != `CFGDEC_IDX_CTRL) begin
			rresp = `CFGDEC_RESP_SLVERR;
		end
		if (q.rsp.rvalid && i_axi.rready) begin
			d.rsp.rvalid = 1'b0;
		end
		if (i_axi.arvalid && q.rsp.arready) begin
			d.rsp.rvalid = 1'b1;
			d.rsp.rdata  = rword;
			d.rsp.rresp  = rresp;
		end
		d.rsp.arready = !d.rsp.rvalid;

		// ======================================================
		// Watchdog tick: free-running divider, stands for its own oscillator
		tick = (q.tick_cnt == `CFGDEC_TICK_W'(`CFGDEC_TICK_DIV - 1));
		d.tick_cnt = tick ? '0 : q.tick_cnt + `CFGDEC_TICK_W'(1);

		// No run-time disable: software may only restart the count
		wdt_to = q.cfg.watchdog_enable_cfg && tick
			&& (q.st == cfgdec_pkg::S_RUN || q.st == cfgdec_pkg::S_SLEEP)
			&& (q.wdt_cnt == `CFGDEC_WDT_W'(WDT_TICKS - 1));
		if (!q.cfg.watchdog_enable_cfg || wdt_clr || wdt_to) begin
			d.wdt_cnt = '0;
		end else if (tick && (q.st == cfgdec_pkg::S_RUN
				|| q.st == cfgdec_pkg::S_SLEEP)) begin
			d.wdt_cnt = q.wdt_cnt + `CFGDEC_WDT_W'(1);
		end
		d.wdt_pulse = wdt_to;
		// Event beats a clear in the same cycle
		if (flag_clr) begin
			d.wdt_flag = 1'b0;
		end
		if (wdt_to) begin
			d.wdt_flag = 1'b1;
		end

		// ======================================================
		// Reset and sleep sequencer
		unique case (q.st)
			cfgdec_pkg::S_SYNC_A: begin
				d.st = cfgdec_pkg::S_SYNC_B;
			end
			cfgdec_pkg::S_SYNC_B: begin
				d.st = cfgdec_pkg::S_CAPTURE;
			end
			cfgdec_pkg::S_CAPTURE: begin
				// Only place the decoded outputs change; held until next power-on
				d.cfg = decode(nvm.word[`CFGDEC_IDX_CFG - `CFGDEC_IDX_SPACE_LO],
					q.rom_s[1]);
				if (!d.cfg.powerup_delay_enable_n) begin
					pud_start = 1'b1;
					d.st = cfgdec_pkg::S_PUD;
				end else begin
					d.st = cfgdec_pkg::S_OSU;
				end
			end
			cfgdec_pkg::S_PUD: begin
				if (pud_done) begin
					d.st = cfgdec_pkg::S_OSU;
				end
			end
			cfgdec_pkg::S_OSU: begin
				// RC mode has no crystal to wait for
				if ({q.cfg.osc_select_hi, q.cfg.osc_select_lo} == `CFGDEC_OSC_RC) begin
					d.st = cfgdec_pkg::S_RUN;
				end else if (!q.osu_armed && q.osc_s[1]) begin
					osu_start   = 1'b1;
					d.osu_armed = 1'b1;
				end else if (osu_done) begin
					d.osu_armed = 1'b0;
					d.st = cfgdec_pkg::S_RUN;
				end
			end
			cfgdec_pkg::S_RUN: begin
				if (!q.mclr_s[1]) begin
					d.st = cfgdec_pkg::S_MCLR;
				end else if (sleep_req) begin
					d.st = cfgdec_pkg::S_SLEEP;
					d.wdt_cnt = '0;
				end
			end
			cfgdec_pkg::S_MCLR: begin
				// Power-up delay is not repeated after a pin reset
				if (q.mclr_s[1]) begin
					d.st = cfgdec_pkg::S_RUN;
				end
			end
			cfgdec_pkg::S_SLEEP: begin
				if (!q.mclr_s[1]) begin
					d.st = cfgdec_pkg::S_MCLR;
				end else if (wdt_to || i_irq) begin
					d.st = cfgdec_pkg::S_OSU;
				end
			end
		endcase

		// Watchdog time-out while running resets the core for one cycle
		d.dev_reset_n = (d.st == cfgdec_pkg::S_RUN || d.st == cfgdec_pkg::S_SLEEP)
			&& !(wdt_to && q.st == cfgdec_pkg::S_RUN);
		d.sleeping = (d.st == cfgdec_pkg::S_SLEEP);
	end

	// ==========================================================
	// State register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	assign o_axi         = q.rsp;
	assign o_cfg         = q.cfg;
	assign o_dev_reset_n = q.dev_reset_n;
	assign o_sleeping    = q.sleeping;
	assign o_wdt_timeout = q.wdt_pulse;

endmodule

// ---- tb/cfgdec_top_assertions.sv ----
// Concurrent checks on the configuration decoder top-level ports
`include "cfgdec_defs.svh"

module cfgdec_top_assertions #(
	parameter int unsigned PUD_CYCLES = 50
) (
	// Clock and power-on reset
	input  wire logic                        i_clk,
	input  wire logic                        i_rst_n,
	// Register bus
	input  wire cfgdec_pkg::cfgdec_axi_req_t i_axi,
	input  wire cfgdec_pkg::cfgdec_axi_rsp_t o_axi,
	// Pins
	input  wire logic                        i_prog_mode,
	input  wire logic                        i_rom_variant,
	input  wire logic                        i_mclr_n,
	input  wire logic                        i_osc_stable,
	input  wire logic                        i_irq,
	// Decoded outputs
	input  wire cfgdec_pkg::cfgdec_cfg_t     o_cfg,
	input  wire logic                        o_dev_reset_n,
	input  wire logic                        o_sleeping,
	input  wire logic                        o_wdt_timeout
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Helper state
	logic [2:0]  pl_q;
	logic [15:0] ar_q;
	logic [31:0] rel_q;
	logic [10:0] stb_q;
	logic        boot_q;

	// Program pin is synchronised, so it must sit low a few cycles first
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pl_q   <= 3'h0;
			ar_q   <= 16'h0;
			rel_q  <= 32'h0;
			stb_q  <= 11'h0;
			boot_q <= 1'b1;
		end else begin
			pl_q   <= i_prog_mode ? 3'h0 : (pl_q == 3'h4 ? pl_q : pl_q + 3'h1);
			ar_q   <= (i_axi.arvalid && o_axi.arready) ? i_axi.araddr : ar_q;
			rel_q  <= rel_q + 32'h1;
			stb_q  <= (i_osc_stable && stb_q != 11'h7FF) ? stb_q + 11'h1 : stb_q;
			boot_q <= o_dev_reset_n ? 1'b0 : boot_q;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	cfg_hold_a: assert property (o_dev_reset_n |-> $stable(o_cfg))
		else $error("decoded configuration moved while running");
	space_guard_a: assert property ((i_axi.arvalid && o_axi.arready && i_axi.araddr[15]
		&& pl_q == 3'h4) |=> (o_axi.rvalid && o_axi.rresp == `CFGDEC_RESP_SLVERR
		&& o_axi.rdata == 32'h0))
		else $error("config space read outside programming mode");
	wdt_gate_a: assert property (o_wdt_timeout |-> o_cfg.watchdog_enable_cfg ##1 !o_wdt_timeout)
		else $error("watchdog timeout while disabled or too long");
	status_map_a: assert property ((o_axi.rvalid && ar_q == 16'h0 && o_axi.rresp == 2'h0)
		|-> o_axi.rdata[5:0] == {o_cfg.data_memory_protect_bit, o_cfg.prog_protect,
		!o_cfg.powerup_delay_enable_n, o_cfg.watchdog_enable_cfg, o_cfg.osc_select_hi,
		o_cfg.osc_select_lo})
		else $error("status fields differ from decoded outputs");
	flash_prot_a: assert property ((o_dev_reset_n && !i_rom_variant)
		|-> o_cfg.prog_protect == o_cfg.data_memory_protect_bit)
		else $error("flash protect outputs disagree");
	pud_min_a: assert property (($rose(o_dev_reset_n) && boot_q
		&& !o_cfg.powerup_delay_enable_n) |-> rel_q >= PUD_CYCLES)
		else $error("power-up delay too short");
	osu_hold_a: assert property (($rose(o_dev_reset_n) && boot_q
		&& {o_cfg.osc_select_hi, o_cfg.osc_select_lo} != `CFGDEC_OSC_RC) |-> stb_q >= 11'h400)
		else $error("released before oscillator settled");
	irq_wake_a: assert property ((o_sleeping && i_irq) |-> ##[1:4] !o_sleeping)
		else $error("interrupt did not wake");
	wdt_wake_a: assert property ((o_sleeping ##1 o_wdt_timeout) |-> !o_sleeping)
		else $error("watchdog did not wake");
	pin_reset_a: assert property (($rose(i_mclr_n) && !boot_q) |-> ##[1:8] o_dev_reset_n)
		else $error("pin reset applied a power-up delay");

	boot_c: cover property ($rose(o_dev_reset_n) && boot_q);
	sleep_c: cover property ($rose(o_sleeping));
	guard_c: cover property (o_axi.rvalid && o_axi.rresp == `CFGDEC_RESP_SLVERR);
endmodule

// ---- tb/cfgdec_osc_model.sv ----
// Crystal stand-in that settles a fixed while after power-on
module cfgdec_osc_model #(
	parameter int unsigned SETTLE = 100
) (
	// Clock and power-on reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Oscillator status pin
	output logic      o_stable
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned cnt;

	// Never stable at release, so the start-up hold is really exercised
	always @(posedge i_clk) begin
		if (!i_rst_n)
			cnt <= 0;
		else if (cnt < SETTLE)
			cnt <= cnt + 1;
	end
	assign o_stable = (cnt >= SETTLE);
endmodule

// ---- tb/cfgdec_tb_top.sv ----
// Self-checking bench for the configuration word decoder
module cfgdec_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Setup
	localparam int unsigned PW = 50;
	localparam int unsigned OSD = 100;
	localparam logic [13:0] WORDS [5] = '{14'h3FEF, 14'h3FF2, 14'h3F7D, 14'h3EF0, 14'h3FFF};
	localparam logic [4:0]  ROMS = 5'h0C;
	logic                        i_clk = 1'b0;
	logic                        i_rst_n = 1'b0;
	cfgdec_pkg::cfgdec_axi_req_t i_axi = '0;
	cfgdec_pkg::cfgdec_axi_rsp_t o_axi;
	logic                        i_prog_mode = 1'b0;
	logic                        i_rom_variant = 1'b0;
	logic                        i_mclr_n = 1'b1;
	logic                        i_osc_stable;
	logic                        i_irq = 1'b0;
	cfgdec_pkg::cfgdec_cfg_t     o_cfg;
	logic                        o_dev_reset_n;
	logic                        o_sleeping;
	logic                        o_wdt_timeout;
	int                          failures = 0;
	int                          tests_run = 0;

	always #20 i_clk = ~i_clk;

	cfgdec_top #(.PUD_CYCLES(PW), .WDT_TICKS(4)) u_cfgdec_top (.i_clk(i_clk),
		.i_rst_n(i_rst_n), .i_axi(i_axi), .o_axi(o_axi), .i_prog_mode(i_prog_mode),
		.i_rom_variant(i_rom_variant), .i_mclr_n(i_mclr_n), .i_osc_stable(i_osc_stable),
		.i_irq(i_irq), .o_cfg(o_cfg), .o_dev_reset_n(o_dev_reset_n), .o_sleeping(o_sleeping),
		.o_wdt_timeout(o_wdt_timeout));
	cfgdec_osc_model #(.SETTLE(OSD)) u_cfgdec_osc_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.o_stable(i_osc_stable));

	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk_rng(input string nm, input int v, input int lo, input int hi);
		tests_run++;
		if (v < lo || v > hi) begin
			failures++;
			$display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, v);
		end
	endtask
	task automatic close_out;
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
		i_axi.awvalid <= 1'b1;
		i_axi.awaddr <= a;
		i_axi.wvalid <= 1'b1;
		i_axi.wdata <= d;
		i_axi.wstrb <= 4'hF;
		i_axi.bready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (o_axi.awready === 1'b1) i_axi.awvalid <= 1'b0;
			if (o_axi.wready === 1'b1) i_axi.wvalid <= 1'b0;
		end while (o_axi.bvalid !== 1'b1);
		r = o_axi.bresp;
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		i_axi.arvalid <= 1'b1;
		i_axi.araddr <= a;
		i_axi.rready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (o_axi.arready === 1'b1) i_axi.arvalid <= 1'b0;
		end while (o_axi.rvalid !== 1'b1);
		d = o_axi.rdata;
		r = o_axi.rresp;
	endtask
	function automatic logic pick(input int s);
		return s == 0 ? o_dev_reset_n : (s == 1 ? o_sleeping : o_wdt_timeout);
	endfunction
	task automatic wt(input int s, input logic v, input int n, output int c);
		c = 0;
		while (pick(s) !== v && c < n) begin
			@(posedge i_clk);
			c++;
		end
	endtask
	// Strap moves only inside reset so no running config sees it change
	task automatic por(input logic rom);
		i_rst_n <= 1'b0;
		@(posedge i_clk);
		i_rom_variant <= rom;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
	endtask
	task automatic prog(input logic on);
		i_prog_mode <= on;
		repeat (4) @(posedge i_clk);
	endtask
	function automatic logic [5:0] exp_cfg(input logic [13:0] w, input logic rom);
		logic pp;
		pp = rom ? ~(&w[13:8] & &w[6:4]) : ~&w[13:4];
		return {pp, rom ? ~w[7] : pp, w[3:0]};
	endfunction

	// ==========================================================
	// Scenarios
	task automatic t_case(input int k);
		logic [13:0] w;
		logic [5:0]  e;
		logic [31:0] d;
		logic [1:0]  r;
		int          c;
		int          lo;
		w = WORDS[k];
		e = exp_cfg(w, ROMS[k]);
		prog(1'b1);
		wr(16'h0004, 32'h8, r);
		rd(16'h8018, d, r);
		chk("erased_word", 32'h3FFF, d);
		wr(16'h801C, {18'h0, w}, r);
		chk("prog_resp", 32'h0, {30'h0, r});
		if (k > 0) chk("cfg_kept", {26'h0, exp_cfg(WORDS[k-1], ROMS[k-1])}, {26'h0, o_cfg});
		rd(16'h801C, d, r);
		chk("cfg_word", {18'h0, w}, d);
		rd(16'h8020, d, r);
		chk("spare_word", 32'h3FFF, d);
		prog(1'b0);
		rd(16'h801C, d, r);
		chk("guard_resp", 32'h2, {30'h0, r});
		por(ROMS[k]);
		wt(0, 1'b1, 3000, c);
		lo = (w[3] ? 0 : PW) + (w[1:0] == 2'h3 ? 0 : 1024);
		chk_rng("boot_cycles", c, lo, lo + OSD + 30);
		chk("cfg_out", {26'h0, e}, {26'h0, o_cfg});
		rd(16'h0000, d, r);
		chk("status", {26'h0, e[4], e[5], ~w[3], w[2:0]}, {26'h0, d[5:0]});
		if (!w[3]) begin
			i_mclr_n <= 1'b0;
			wt(0, 1'b0, 8, c);
			i_mclr_n <= 1'b1;
			wt(0, 1'b1, 12, c);
			chk_rng("pin_reset_cycles", c, 1, 8);
		end
		if (!w[2]) begin
			wt(2, 1'b1, 300, c);
			chk_rng("wdt_quiet", c, 300, 300);
		end
	endtask
	// Runs with the erased word: RC, watchdog on, no power-up delay
	task automatic t_wdt;
		logic [31:0] d;
		logic [1:0]  r;
		int          c;
		wt(2, 1'b1, 200, c);
		chk_rng("wdt_period", c, 1, 130);
		rd(16'h0000, d, r);
		chk("wdt_flag", 32'h1, {31'h0, d[8]});
		wr(16'h0004, 32'h4, r);
		rd(16'h0000, d, r);
		chk("wdt_flag_clr", 32'h0, {31'h0, d[8]});
		wr(16'h0004, 32'h2, r);
		wt(2, 1'b1, 200, c);
		chk_rng("wdt_after_restart", c, 60, 130);
		wr(16'h0004, 32'h1, r);
		@(posedge i_clk);
		chk("asleep", 32'h1, {31'h0, o_sleeping});
		i_irq <= 1'b1;
		wt(1, 1'b0, 10, c);
		i_irq <= 1'b0;
		chk_rng("irq_wake", c, 1, 6);
		wr(16'h0004, 32'h1, r);
		wt(1, 1'b0, 200, c);
		chk_rng("wdt_wake", c, 60, 130);
		wr(16'h0004, 32'h1, r);
		@(posedge i_clk);
		i_mclr_n <= 1'b0;
		wt(1, 1'b0, 10, c);
		chk_rng("pin_wake", c, 1, 6);
		i_mclr_n <= 1'b1;
		wt(0, 1'b1, 10, c);
		chk("run_again", 32'h1, {31'h0, o_dev_reset_n});
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		@(posedge i_clk);
		por(1'b0);
		prog(1'b1);
		wr(16'h0004, 32'h8, r);
		por(1'b0);
		rd(16'h0008, d, r);
		chk("unmapped_resp", 32'h2, {30'h0, r});
		for (int k = 0; k < 5; k++) t_case(k);
		t_wdt();
		close_out();
	end
	initial begin
		repeat (60000) @(posedge i_clk);
		failures++;
		close_out();
	end
endmodule

bind cfgdec_top cfgdec_top_assertions #(.PUD_CYCLES(PUD_CYCLES)) u_cfgdec_top_assertions (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_axi(i_axi), .o_axi(o_axi),
	.i_prog_mode(i_prog_mode), .i_rom_variant(i_rom_variant), .i_mclr_n(i_mclr_n),
	.i_osc_stable(i_osc_stable), .i_irq(i_irq), .o_cfg(o_cfg),
	.o_dev_reset_n(o_dev_reset_n), .o_sleeping(o_sleeping), .o_wdt_timeout(o_wdt_timeout));
